// file: rtl/dgp_port.sv
// dual eight bit port with peripheral override and slave data mode
//
// Chosen here: the strobed register port.
`include "dgp_cfg.svh"
`default_nettype none
module dgp_port (
   input wire logic mclk,
   input wire logic rst,
   input wire logic porRst,
   input wire dgp_pkg::dgp_bus_t bus,
   output logic [7:0] rdata,
   input wire dgp_pkg::dgp_periph_t periph,
   output logic [7:0] periphIn,
   input wire dgp_pkg::dgp_slave_flags_t slaveFlags,
   input wire logic [7:0] slaveBusOut,
   input wire logic slaveBusOe,
   output logic [7:0] slaveBusIn,
   output logic slaveMode,
   output logic [2:0] thirdDir,
   input wire logic [7:0] firstPinIn,
   output logic [7:0] firstPinOut,
   output logic [7:0] firstPinOe,
   input wire logic [7:0] secondPinIn,
   output logic [7:0] secondPinOut,
   output logic [7:0] secondPinOe
);
   // ****************************************
   // register decode
   // ****************************************
   logic [7:0] firstLatch_q, secondLatch_q, firstDir_q, secondDir_q, ctrl_q;
   logic [7:0] firstSync1_q, firstSync_q, secondSync1_q, secondSync_q;
   logic [7:0] rdata_q, rdata_d;
   logic porDone_q, porSync1_q, porSync_q;
   wire wrFirstData = bus.wr && (bus.addr == `DGP_ADDR_FIRST_DATA);
   wire wrSecondData = bus.wr && (bus.addr == `DGP_ADDR_SECOND_DATA);
   wire wrFirstDir = bus.wr && (bus.addr == `DGP_ADDR_FIRST_DIR);
   wire wrSecondDir = bus.wr && (bus.addr == `DGP_ADDR_SECOND_DIR);
   wire wrCtrl = bus.wr && (bus.addr == `DGP_ADDR_THIRD_CTRL);
   wire rdFirstData = bus.rd && (bus.addr == `DGP_ADDR_FIRST_DATA);
   wire rdSecondData = bus.rd && (bus.addr == `DGP_ADDR_SECOND_DATA);
   wire rdFirstDir = bus.rd && (bus.addr == `DGP_ADDR_FIRST_DIR);
   wire rdSecondDir = bus.rd && (bus.addr == `DGP_ADDR_SECOND_DIR);
   wire rdCtrl = bus.rd && (bus.addr == `DGP_ADDR_THIRD_CTRL);
   wire rdMapped = rdFirstData || rdSecondData || rdFirstDir || rdSecondDir || rdCtrl;
   wire [7:0] ctrlView = {slaveFlags.inFull, slaveFlags.outFull, slaveFlags.inOvf,
                          ctrl_q[`DGP_BIT_SLAVEMODE], 1'b0, ctrl_q[2:0]};
   assign slaveMode = ctrl_q[`DGP_BIT_SLAVEMODE];
   assign thirdDir = ctrl_q[2:0];

   // ****************************************
   // register storage
   // ****************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         firstDir_q <= `DGP_DIR_RESET;
         secondDir_q <= `DGP_DIR_RESET;
         ctrl_q <= `DGP_CTRL_RESET;
      end else begin
         if (wrFirstDir) begin
            firstDir_q <= bus.wdata;
         end
         if (wrSecondDir) begin
            secondDir_q <= bus.wdata;
         end
         if (wrCtrl) begin
            ctrl_q <= bus.wdata & `DGP_CTRL_WMASK;
         end
      end
   end

   // power-on level comes from outside the clock domain
   always_ff @(posedge mclk) begin
      porSync1_q <= porRst;
      porSync_q <= porSync1_q;
   end

   // latches are not reset; power-on clears them only to a defined value
   always_ff @(posedge mclk) begin
      porDone_q <= !porSync_q;
      if (porSync_q && !porDone_q) begin
         firstLatch_q <= 8'h00;
         secondLatch_q <= 8'h00;
      end else begin
         if (wrFirstData) begin
            firstLatch_q <= bus.wdata;
         end
         if (wrSecondData) begin
            secondLatch_q <= bus.wdata;
         end
      end
   end

   // ****************************************
   // pin synchronisers and read path
   // ****************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         firstSync1_q <= 8'h00;
         firstSync_q <= 8'h00;
         secondSync1_q <= 8'h00;
         secondSync_q <= 8'h00;
         rdata_q <= 8'h00;
      end else begin
         firstSync1_q <= firstPinIn;
         firstSync_q <= firstSync1_q;
         secondSync1_q <= secondPinIn;
         secondSync_q <= secondSync1_q;
         rdata_q <= rdata_d;
      end
   end

   always_comb begin
      rdata_d = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            `DGP_ADDR_FIRST_DATA: rdata_d = firstSync_q;
            `DGP_ADDR_SECOND_DATA: rdata_d = secondSync_q;
            `DGP_ADDR_FIRST_DIR: rdata_d = firstDir_q;
            `DGP_ADDR_SECOND_DIR: rdata_d = secondDir_q;
            `DGP_ADDR_THIRD_CTRL: rdata_d = ctrlView;
            default: rdata_d = 8'h00;
         endcase
      end
   end
   assign rdata = rdata_q;
   assign periphIn = firstSync_q;
   assign slaveBusIn = secondSync_q;

   // ****************************************
   // first and second port pin drivers
   // ****************************************
   // peripherals on bits 0..5 are fed by periph; bits 6,7 use sel low
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : gFirst
         // select picks data source and who owns the enable
         assign firstPinOut[i] = periph.sel[i] ? periph.dout[i] : firstLatch_q[i];
         assign firstPinOe[i] = periph.sel[i] ? periph.oe[i] : !firstDir_q[i];
      end
      for (i = 0; i < 8; i = i + 1) begin : gSecond
         assign secondPinOut[i] = slaveMode ? slaveBusOut[i] : secondLatch_q[i];
         assign secondPinOe[i] = slaveMode ? slaveBusOe : !secondDir_q[i];
      end
   endgenerate

   // ****************************************
   // checks
   // ****************************************
   property p_dirInput;
      @(posedge mclk) disable iff (rst) (!periph.sel[0] && firstDir_q[0]) |-> !firstPinOe[0];
   endproperty
   a_dirInput: assert property (p_dirInput) else $error("input pin driven");

   property p_dirOutput;
      @(posedge mclk) disable iff (rst)
         (!periph.sel[7] && !firstDir_q[7]) |-> (firstPinOe[7] && firstPinOut[7] == firstLatch_q[7]);
   endproperty
   a_dirOutput: assert property (p_dirOutput) else $error("output pin not driving latch");

   property p_override;
      @(posedge mclk) disable iff (rst) periph.sel[2] |-> firstPinOe[2] == periph.oe[2];
   endproperty
   a_override: assert property (p_override) else $error("override ignored");

   property p_selData;
      @(posedge mclk) disable iff (rst) periph.sel[5] |-> firstPinOut[5] == periph.dout[5];
   endproperty
   a_selData: assert property (p_selData) else $error("peripheral data not selected");

   property p_oeGate;
      @(posedge mclk) disable iff (rst) (!periph.sel[3] && periph.oe[3]) |-> firstPinOe[3] == !firstDir_q[3];
   endproperty
   a_oeGate: assert property (p_oeGate) else $error("peripheral enable leaked");

   sequence s_wrDir;
      bus.wr && bus.addr == `DGP_ADDR_FIRST_DIR;
   endsequence
   property p_dirWrite;
      @(posedge mclk) disable iff (rst) s_wrDir ##1 !periph.sel[4] |-> firstPinOe[4] == !$past(bus.wdata[4]);
   endproperty
   a_dirWrite: assert property (p_dirWrite) else $error("direction write lost");

   property p_slave;
      @(posedge mclk) disable iff (rst) slaveMode |-> secondPinOut == slaveBusOut;
   endproperty
   a_slave: assert property (p_slave) else $error("slave bus not on second port");

   property p_readCtrl;
      @(posedge mclk) disable iff (rst)
         (bus.rd && bus.addr == `DGP_ADDR_THIRD_CTRL) |=> rdata[3] == 1'b0;
   endproperty
   a_readCtrl: assert property (p_readCtrl) else $error("unused bit read nonzero");

   property p_resetDir;
      @(posedge mclk) $fell(rst) |-> (firstDir_q == `DGP_DIR_RESET && ctrl_q == `DGP_CTRL_RESET);
   endproperty
   a_resetDir: assert property (p_resetDir) else $error("reset values wrong");

   property p_latchWrite;
      @(posedge mclk) disable iff (rst) (wrFirstData && !porSync_q) |=> firstLatch_q == $past(bus.wdata);
   endproperty
   a_latchWrite: assert property (p_latchWrite) else $error("latch write lost");

   // ****************************************
   // checks: pin drivers, whole ports and timer and serial bit groups
   // ****************************************
   property p_inputAll;
      @(posedge mclk) disable iff (rst)
         (firstPinOe & ~periph.sel & firstDir_q) == 8'h00;
   endproperty
   a_inputAll: assert property (p_inputAll) else $error("first port input pin driven");

   property p_outputAll;
      @(posedge mclk) disable iff (rst)
         (~firstPinOe & ~periph.sel & ~firstDir_q) == 8'h00;
   endproperty
   a_outputAll: assert property (p_outputAll) else $error("first port output pin not driven");

   property p_latchPin;
      @(posedge mclk) disable iff (rst)
         ((firstPinOut ^ firstLatch_q) & ~periph.sel) == 8'h00;
   endproperty
   a_latchPin: assert property (p_latchPin) else $error("latch not on first port pin");

   property p_selDataAll;
      @(posedge mclk) disable iff (rst)
         ((firstPinOut ^ periph.dout) & periph.sel) == 8'h00;
   endproperty
   a_selDataAll: assert property (p_selDataAll) else $error("peripheral data not on pin");

   property p_forceOut;
      @(posedge mclk) disable iff (rst)
         (~firstPinOe & periph.sel & periph.oe) == 8'h00;
   endproperty
   a_forceOut: assert property (p_forceOut) else $error("peripheral output not forced");

   property p_forceIn;
      @(posedge mclk) disable iff (rst)
         (firstPinOe & periph.sel & ~periph.oe) == 8'h00;
   endproperty
   a_forceIn: assert property (p_forceIn) else $error("peripheral input not forced");

   property p_oeGateAll;
      @(posedge mclk) disable iff (rst)
         ((firstPinOe ^ ~firstDir_q) & ~periph.sel) == 8'h00;
   endproperty
   a_oeGateAll: assert property (p_oeGateAll) else $error("unselected peripheral enable leaked");

   property p_timerPins;
      @(posedge mclk) disable iff (rst)
         (periph.sel[1:0] == 2'b11) |-> (firstPinOe[1:0] == periph.oe[1:0] && firstPinOut[1:0] == periph.dout[1:0]);
   endproperty
   a_timerPins: assert property (p_timerPins) else $error("timer pins not overridden");

   property p_serialPins;
      @(posedge mclk) disable iff (rst)
         (periph.sel[5:3] == 3'b111) |-> firstPinOe[5:3] == periph.oe[5:3];
   endproperty
   a_serialPins: assert property (p_serialPins) else $error("serial pins not overridden");

   property p_periphIn;
      @(posedge mclk) disable iff (rst)
         (!$past(rst) && !$past(rst, 2)) |-> periphIn == $past(firstPinIn, 2);
   endproperty
   a_periphIn: assert property (p_periphIn) else $error("peripheral input not synced pin");

   property p_dirWidth;
      @(posedge mclk) disable iff (rst)
         wrFirstDir |=> firstDir_q == $past(bus.wdata);
   endproperty
   a_dirWidth: assert property (p_dirWidth) else $error("first direction write lost");

   property p_secondIn;
      @(posedge mclk) disable iff (rst)
         !slaveMode |-> (secondPinOe & secondDir_q) == 8'h00;
   endproperty
   a_secondIn: assert property (p_secondIn) else $error("second port input pin driven");

   property p_secondOut;
      @(posedge mclk) disable iff (rst)
         !slaveMode |-> ((secondPinOe | secondDir_q) == 8'hff && secondPinOut == secondLatch_q);
   endproperty
   a_secondOut: assert property (p_secondOut) else $error("second port output wrong");

   property p_slaveOe;
      @(posedge mclk) disable iff (rst)
         slaveMode |-> secondPinOe == {8{slaveBusOe}};
   endproperty
   a_slaveOe: assert property (p_slaveOe) else $error("slave bus enable not on pins");

   sequence s_slaveOn;
      wrCtrl && bus.wdata[`DGP_BIT_SLAVEMODE];
   endsequence
   property p_slaveEnter;
      @(posedge mclk) disable iff (rst)
         s_slaveOn |=> slaveMode;
   endproperty
   a_slaveEnter: assert property (p_slaveEnter) else $error("slave mode not entered");

   property p_slaveIn;
      @(posedge mclk) disable iff (rst)
         (!$past(rst) && !$past(rst, 2)) |-> slaveBusIn == $past(secondPinIn, 2);
   endproperty
   a_slaveIn: assert property (p_slaveIn) else $error("slave bus input not synced pin");

   property p_secondWrite;
      @(posedge mclk) disable iff (rst)
         (wrSecondData && !porSync_q) |=> secondLatch_q == $past(bus.wdata);
   endproperty
   a_secondWrite: assert property (p_secondWrite) else $error("second latch write lost");

   property p_latchKeep;
      @(posedge mclk)
         (!wrFirstData && !porSync_q) |=> $stable(firstLatch_q);
   endproperty
   a_latchKeep: assert property (p_latchKeep) else $error("first latch changed");

   property p_secondKeep;
      @(posedge mclk)
         (!wrSecondData && !porSync_q) |=> $stable(secondLatch_q);
   endproperty
   a_secondKeep: assert property (p_secondKeep) else $error("second latch changed");

   // ****************************************
   // checks: register bus
   // ****************************************
   property p_readFirst;
      @(posedge mclk) disable iff (rst)
         rdFirstData |=> rdata == $past(firstSync_q);
   endproperty
   a_readFirst: assert property (p_readFirst) else $error("first data read wrong");

   property p_readSecond;
      @(posedge mclk) disable iff (rst)
         rdSecondData |=> rdata == $past(secondSync_q);
   endproperty
   a_readSecond: assert property (p_readSecond) else $error("second data read wrong");

   property p_readFirstDir;
      @(posedge mclk) disable iff (rst)
         rdFirstDir |=> rdata == $past(firstDir_q);
   endproperty
   a_readFirstDir: assert property (p_readFirstDir) else $error("first direction read wrong");

   property p_readSecondDir;
      @(posedge mclk) disable iff (rst)
         rdSecondDir |=> rdata == $past(secondDir_q);
   endproperty
   a_readSecondDir: assert property (p_readSecondDir) else $error("second direction read wrong");

   property p_readFlags;
      @(posedge mclk) disable iff (rst)
         rdCtrl |=> rdata[7:5] == $past({slaveFlags.inFull, slaveFlags.outFull, slaveFlags.inOvf});
   endproperty
   a_readFlags: assert property (p_readFlags) else $error("status flags read wrong");

   property p_readUnmapped;
      @(posedge mclk) disable iff (rst)
         (bus.rd && !rdMapped) |=> rdata == 8'h00;
   endproperty
   a_readUnmapped: assert property (p_readUnmapped) else $error("unmapped read nonzero");

   property p_readIdle;
      @(posedge mclk) disable iff (rst)
         !bus.rd |=> rdata == 8'h00;
   endproperty
   a_readIdle: assert property (p_readIdle) else $error("read data without read");

   property p_ctrlMask;
      @(posedge mclk) disable iff (rst)
         wrCtrl |=> ctrl_q == ($past(bus.wdata) & `DGP_CTRL_WMASK);
   endproperty
   a_ctrlMask: assert property (p_ctrlMask) else $error("control write mask wrong");

   property p_resetSecond;
      @(posedge mclk)
         $fell(rst) |-> secondDir_q == `DGP_DIR_RESET;
   endproperty
   a_resetSecond: assert property (p_resetSecond) else $error("second direction reset wrong");

   property p_resetThird;
      @(posedge mclk)
         $fell(rst) |-> (thirdDir == 3'h7 && !slaveMode);
   endproperty
   a_resetThird: assert property (p_resetThird) else $error("third control reset wrong");
endmodule
`default_nettype wire

// file: rtl/dgp_cfg.svh
// constants for the dual port block with peripheral override
// Summary of operation
// - first port direction bit 1 makes pin input, driver off
// - first port direction bit 0 drives the output latch onto the pin
// - first port is eight bits, one direction bit per pin
// - enabled peripheral overrides pin direction, forcing output or input
// - per pin select picks port latch or peripheral output
// - peripheral output enable only counts while its select is active
// - bit 0 timer osc out or clock in, bit 1 timer osc in
// - bit 2 is capture input, compare or pwm output
// - bit 3 serial clock, bit 4 serial data in, bit 5 data out
// - second port is eight bits, each pin with its own direction
// - slave mode bit 4 of third control turns second port to data port
// - in slave mode second port pin n carries slave bus bit n
// - directions at 87h 88h 89h, data registers at 07h 08h
// - all resets set first and second direction registers to ones; here only rst does, porRst leaves them unchanged
// - data latches unknown at power-on, unchanged by other resets; here power-on clears them to 00h
// - third control holds flags 7..5, slave mode bit 4, zero bit 3, directions 2..0
// - third control resets to 0000 -111
`ifndef DGP_CFG_SVH
`define DGP_CFG_SVH
`define DGP_ADDR_FIRST_DATA 8'h07
`define DGP_ADDR_SECOND_DATA 8'h08
`define DGP_ADDR_FIRST_DIR 8'h87
`define DGP_ADDR_SECOND_DIR 8'h88
`define DGP_ADDR_THIRD_CTRL 8'h89
`define DGP_DIR_RESET 8'hff
`define DGP_CTRL_RESET 8'h07
`define DGP_CTRL_WMASK 8'h17
`define DGP_BIT_INFULL 7
`define DGP_BIT_OUTFULL 6
`define DGP_BIT_INOVF 5
`define DGP_BIT_SLAVEMODE 4
`define DGP_BIT_TIMER_OSO 0
`define DGP_BIT_TIMER_OSI 1
`define DGP_BIT_CCP 2
`define DGP_BIT_SERCLK 3
`define DGP_BIT_SERDIN 4
`define DGP_BIT_SERDOUT 5
`endif

// file: rtl/dgp_pkg.sv
// types for the dual port block
`default_nettype none
package dgp_pkg;
   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] oe;
      logic [7:0] dout;
   } dgp_periph_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dgp_bus_t;
   typedef struct packed {
      logic inFull;
      logic outFull;
      logic inOvf;
   } dgp_slave_flags_t;
endpackage
`default_nettype wire

// file: tb/dgp_pin_model.sv
// pin side model: external drivers and floating lines
`default_nettype none
module dgp_pin_model (
   input wire logic mclk,
   input wire logic [7:0] firstPinOut,
   input wire logic [7:0] firstPinOe,
   input wire logic [7:0] secondPinOut,
   input wire logic [7:0] secondPinOe,
   input wire logic [7:0] extFirst,
   input wire logic [7:0] extFirstOe,
   input wire logic [7:0] extSecond,
   input wire logic [7:0] extSecondOe,
   output logic [7:0] firstPinIn,
   output logic [7:0] secondPinIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] floatQ = 8'h5a;
   // undriven lines wander every cycle
   always @(posedge mclk) floatQ <= ~floatQ;
   assign firstPinIn = (firstPinOe & firstPinOut) | (~firstPinOe & ((extFirstOe & extFirst) | (~extFirstOe & floatQ)));
   assign secondPinIn = (secondPinOe & secondPinOut) |
      (~secondPinOe & ((extSecondOe & extSecond) | (~extSecondOe & floatQ)));
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// bench for the dual port block
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, porRst, slaveBusOe, slaveMode;
   dgp_pkg::dgp_bus_t bus;
   dgp_pkg::dgp_periph_t periph;
   dgp_pkg::dgp_slave_flags_t slaveFlags;
   logic [7:0] rdata, periphIn, slaveBusOut, slaveBusIn, firstPinIn, firstPinOut, firstPinOe;
   logic [7:0] secondPinIn, secondPinOut, secondPinOe, extFirst, extFirstOe, extSecond, extSecondOe, eOe;
   logic [2:0] thirdDir;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   dgp_pkg::dgp_periph_t pTab [5] = '{'{8'h01, 8'h01, 8'h01},
      '{8'h02, 8'h00, 8'h00},
      '{8'h04, 8'h04, 8'h00},
      '{8'h38, 8'h28, 8'h20},
      '{8'h00, 8'hff, 8'hff}};
   dgp_port dut_u (.mclk(mclk), .rst(rst), .porRst(porRst), .bus(bus), .rdata(rdata), .periph(periph),
      .periphIn(periphIn), .slaveFlags(slaveFlags), .slaveBusOut(slaveBusOut), .slaveBusOe(slaveBusOe),
      .slaveBusIn(slaveBusIn), .slaveMode(slaveMode), .thirdDir(thirdDir), .firstPinIn(firstPinIn),
      .firstPinOut(firstPinOut), .firstPinOe(firstPinOe), .secondPinIn(secondPinIn),
      .secondPinOut(secondPinOut), .secondPinOe(secondPinOe));
   dgp_pin_model pins_u (.mclk(mclk), .firstPinOut(firstPinOut), .firstPinOe(firstPinOe),
      .secondPinOut(secondPinOut), .secondPinOe(secondPinOe), .extFirst(extFirst), .extFirstOe(extFirstOe),
      .extSecond(extSecond), .extSecondOe(extSecondOe), .firstPinIn(firstPinIn), .secondPinIn(secondPinIn));
   always #5 mclk = ~mclk;
   task automatic wrap_up;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) bus <= {a, d, 2'b10};
      @(posedge mclk) bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk) bus <= {a, 8'h00, 2'b01};
      @(posedge mclk) bus <= '0;
      #1 `CHK("rdata", e, rdata)
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         wrap_up;
      end
   end
   initial begin
      mclk = 0;
      rst = 1;
      porRst = 1;
      bus = '0;
      periph = '0;
      slaveFlags = '0;
      slaveBusOut = '0;
      slaveBusOe = 0;
      extFirst = 8'h0a;
      extFirstOe = 8'h0f;
      extSecond = '0;
      extSecondOe = '0;
      repeat (8) @(posedge mclk);
      rst <= 0;
      porRst <= 0;
      rd(8'h87, 8'hff);
      rd(8'h88, 8'hff);
      rd(8'h89, 8'h07);
      rd(8'h10, 8'h00);
      `CHK("oeRst", 8'h00, firstPinOe)
      wr(8'h07, 8'h55);
      wr(8'h87, 8'h0f);
      #1 `CHK("oeDir", 8'hf0, firstPinOe)
      `CHK("outLat", 8'h50, firstPinOut & 8'hf0)
      repeat (3) @(posedge mclk);
      rd(8'h07, 8'h5a);
      `CHK("perIn", 8'h5a, periphIn)
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk) periph <= pTab[i];
         @(posedge mclk) #1;
         eOe = (pTab[i].sel & pTab[i].oe) | (~pTab[i].sel & 8'hf0);
         `CHK("perOe", eOe, firstPinOe)
         `CHK("perOut", ((pTab[i].sel & pTab[i].dout) | (~pTab[i].sel & 8'h55)) & eOe, firstPinOut & eOe)
      end
      periph <= '0;
      wr(8'h88, 8'hf0);
      wr(8'h08, 8'ha5);
      #1 `CHK("dOe", 8'h0f, secondPinOe)
      `CHK("dOut", 8'h05, secondPinOut & 8'h0f)
      slaveFlags <= 3'b101;
      slaveBusOut <= 8'h3c;
      slaveBusOe <= 1;
      wr(8'h89, 8'hff);
      #1 `CHK("mode", 1'b1, slaveMode)
      `CHK("dir3", 3'h7, thirdDir)
      `CHK("psOe", 8'hff, secondPinOe)
      `CHK("psOut", 8'h3c, secondPinOut)
      rd(8'h89, 8'hb7);
      repeat (2) @(posedge mclk);
      #1 `CHK("psIn", 8'h3c, slaveBusIn)
      @(posedge mclk) rst <= 1;
      repeat (2) @(posedge mclk);
      rst <= 0;
      rd(8'h89, 8'ha7);
      rd(8'h87, 8'hff);
      rd(8'h88, 8'hff);
      wr(8'h87, 8'h00);
      #1 `CHK("keep", 8'h55, firstPinOut)
      `CHK("keep2", 8'ha5, secondPinOut)
      wrap_up;
   end
endmodule
`default_nettype wire
